/* core/operand_specifier_address_unit.sv */
// Operand specifier decoder and operand address calculator
//
// Functional notes
// RULE1 - Modes 10/12/14: byte/word/long displacement follows
// RULE2 - Sign-extended displacement plus base gives address
// RULE3 - Modes 11/13/15: fetched longword is address
// RULE4 - PC base uses PC past extension
// RULE5 - Literal zero-extends six bits for integers
// RULE6 - F/D literal: exponent plus 128, fraction
// RULE7 - G literal: exponent plus 1024, fraction
// RULE8 - H literal: exponent plus 16384, second word fraction
// RULE9 - Literal with modify/write/address access faults
// RULE10 - Mode 4: index register, base specifier follows
// RULE11 - Index base register/literal/index mode faults
// RULE12 - Index base keeps its standalone restrictions
// RULE13 - Indexed address adds index times operand size
// RULE14 - Indexed autoinc/autodec steps by primary size
// RULE15 - PC as index register: reserved mode fault
// RULE16 - Stream avoids index equal modified base
// RULE17 - Immediate indexed address ignores constant bytes
// RULE18 - Autoincrement: address first, then register plus size
// RULE19 - Fault reported; no memory access, no register update
`timescale 1ns/1ns
`include "opspec_cfg.svh"

module operand_specifier_address_unit
  import opspec_pkg::*;
(
  input  wire logic         CLK_SYS,           // Processor clock, 250 MHz
  input  wire logic         RST,               // Asynchronous reset, active high
  input  wire logic         START,             // Begin one specifier
  input  wire logic [1:0]   ACCESS,            // Access type, taken with START
  input  wire logic [3:0]   DATA_TYPE,         // Operand data type, taken with START
  input  wire logic         IS_VALID,          // Stream byte present
  input  wire logic [7:0]   IS_BYTE,           // Stream byte
  input  wire logic [31:0]  IS_PC,             // Address of the stream byte
  output logic              IS_READY,          // Stream byte consumed
  output logic [3:0]        REG_A_NUM,         // Base register number
  input  wire logic [31:0]  REG_A_DATA,        // Base register contents
  output logic [3:0]        REG_X_NUM,         // Index register number
  input  wire logic [31:0]  REG_X_DATA,        // Index register contents
  output logic              MEM_REQ,           // Deferred longword read request
  output logic [31:0]       MEM_ADDR,          // Deferred longword address
  input  wire logic         MEM_ACK,           // Deferred read answered
  input  wire logic [31:0]  MEM_DATA,          // Deferred longword
  output logic              DONE,              // Specifier finished, one cycle
  output logic [31:0]       OPERAND_LOCATION,  // Operand address
  output logic              OPND_IS_LITERAL,   // Result is the literal value
  output logic [127:0]      LITERAL_VALUE,     // Literal operand
  output logic              OPND_IN_REG,       // Operand is register (number in address)
  output logic [31:0]       UPDATED_PC,        // PC past the specifier
  output logic              REG_WR_EN,         // Register update strobe
  output logic [3:0]        REG_WR_NUM,        // Register updated
  output logic [31:0]       REG_WR_DATA,       // New register contents
  output logic              FAULT,             // Addressing fault
  output logic [1:0]        FAULT_TYPE         // Illegal or reserved mode
);

  unit_state_t s;
  unit_state_t next_s;
  logic        accept;
  logic [31:0] base;

  function automatic logic [31:0] size_bytes(input dtype_t dt);
    case (dt)
      DT_BYTE:                   size_bytes = 32'h1;
      DT_WORD:                   size_bytes = 32'h2;
      DT_LONG, DT_FFLT:          size_bytes = 32'h4;
      DT_QUAD, DT_DFLT, DT_GFLT: size_bytes = 32'h8;
      default:                   size_bytes = 32'h10;
    endcase
  endfunction : size_bytes

  function automatic logic [31:0] scaled(input logic [31:0] x, input dtype_t dt);
    case (dt)
      DT_BYTE:                   scaled = x;
      DT_WORD:                   scaled = {x[30:0], 1'b0};
      DT_LONG, DT_FFLT:          scaled = {x[29:0], 2'b00};
      DT_QUAD, DT_DFLT, DT_GFLT: scaled = {x[28:0], 3'b000};
      default:                   scaled = {x[27:0], 4'b0000};
    endcase
  endfunction : scaled

  // Bytes of extension that follow a specifier byte
  function automatic logic [2:0] ext_len(input logic [7:0] b);
    case (b[7:4])
      `MODE_BDISP, `MODE_BDISP_DEF: ext_len = 3'h1;                 // RULE1
      `MODE_WDISP, `MODE_WDISP_DEF: ext_len = 3'h2;                 // RULE1
      `MODE_LDISP, `MODE_LDISP_DEF: ext_len = 3'h4;                 // RULE1
      `MODE_AUTOINC_DEF:            ext_len = (b[3:0] == `REG_PC) ? 3'h4 : 3'h0;
      default:                      ext_len = 3'h0;
    endcase
  endfunction : ext_len

  function automatic logic [31:0] disp_ext(input logic [31:0] e, input logic [2:0] n);
    case (n)
      3'h1:    disp_ext = {{24{e[7]}}, e[7:0]};                     // RULE2
      3'h2:    disp_ext = {{16{e[15]}}, e[15:0]};                   // RULE2
      default: disp_ext = e;                                        // RULE2
    endcase
  endfunction : disp_ext

  function automatic logic [127:0] lit_build(input dtype_t dt, input logic [5:0] l);
    lit_build = '0;
    case (dt)
      DT_FFLT, DT_DFLT: lit_build[15:0] = {1'b0, `BIAS_FD + {5'h00, l[5:3]}, l[2:0], 4'h0}; // RULE6
      DT_GFLT: lit_build[15:0] = {1'b0, `BIAS_G + {8'h00, l[5:3]}, l[2:0], 1'b0};         // RULE7
      DT_HFLT: begin
        lit_build[15:0]  = {1'b0, `BIAS_H + {12'h000, l[5:3]}};    // RULE8
        lit_build[31:16] = {l[2:0], 13'h0000};                     // RULE8
      end
      default: lit_build[5:0] = l;                                 // RULE5
    endcase
  endfunction : lit_build

  assign accept    = IS_VALID && (s.st == S_SPEC || s.st == S_BASE || s.st == S_EXT);
  assign IS_READY  = (s.st == S_SPEC || s.st == S_BASE || s.st == S_EXT);
  assign REG_A_NUM = s.rn;
  assign REG_X_NUM = s.rx;
  assign base      = (s.rn == `REG_PC) ? s.pc : REG_A_DATA;        // RULE4

  always_comb begin
    next_s = s;
    case (s.st)
      S_IDLE: begin
        next_s.fault      = 1'b0;
        next_s.fault_type = `FAULT_NONE;
        next_s.wr_en      = 1'b0;
        next_s.in_reg     = 1'b0;
        next_s.is_lit     = 1'b0;
        next_s.indexed    = 1'b0;
        next_s.rx         = 4'h0;
        if (START) begin
          next_s.acc   = access_t'(ACCESS);
          next_s.dtype = dtype_t'(DATA_TYPE);
          next_s.st    = S_SPEC;
        end
      end
      S_SPEC: begin
        if (accept) begin
          next_s.pc       = IS_PC + 32'h1;
          next_s.mode     = IS_BYTE[7:4];
          next_s.rn       = IS_BYTE[3:0];
          next_s.ext      = '0;
          next_s.ext_cnt  = 3'h0;
          next_s.ext_need = ext_len(IS_BYTE);
          next_s.st       = S_FIN;
          if (IS_BYTE[7:6] == 2'b00) begin
            if (s.acc != ACC_READ) begin
              next_s.fault      = 1'b1;                             // RULE9
              next_s.fault_type = `FAULT_ILLEGAL;                   // RULE9
            end else begin
              next_s.is_lit = 1'b1;
              next_s.lit    = lit_build(s.dtype, IS_BYTE[5:0]);     // RULE5
            end
          end else if (IS_BYTE[7:4] == `MODE_INDEX) begin
            next_s.indexed = 1'b1;                                  // RULE10
            next_s.rx      = IS_BYTE[3:0];                          // RULE10
            if (IS_BYTE[3:0] == `REG_PC) begin
              next_s.fault      = 1'b1;                             // RULE15
              next_s.fault_type = `FAULT_RESERVED;                  // RULE15
            end else begin
              next_s.st = S_BASE;                                   // RULE10
            end
          end else if (IS_BYTE[7:4] == `MODE_REG) begin
            if (s.acc == ACC_ADDR) begin
              next_s.fault      = 1'b1;
              next_s.fault_type = `FAULT_ILLEGAL;
            end else begin
              next_s.in_reg = 1'b1;
              next_s.oa     = {28'h0000000, IS_BYTE[3:0]};
            end
          end else begin
            next_s.st = (ext_len(IS_BYTE) == 3'h0) ? S_CALC : S_EXT;
          end
        end
      end
      S_BASE: begin
        if (accept) begin
          next_s.pc       = IS_PC + 32'h1;
          next_s.mode     = IS_BYTE[7:4];
          next_s.rn       = IS_BYTE[3:0];
          next_s.ext      = '0;
          next_s.ext_cnt  = 3'h0;
          next_s.ext_need = ext_len(IS_BYTE);
          if (IS_BYTE[7:4] <= `MODE_REG) begin
            next_s.fault      = 1'b1;                               // RULE11
            next_s.fault_type = `FAULT_ILLEGAL;                     // RULE11
            next_s.st         = S_FIN;
          end else begin
            next_s.st = (ext_len(IS_BYTE) == 3'h0) ? S_CALC : S_EXT; // RULE10 RULE12
          end
        end
      end
      S_EXT: begin
        if (accept) begin
          next_s.pc                               = IS_PC + 32'h1;  // RULE4
          next_s.ext[{s.ext_cnt[1:0], 3'b000} +: 8] = IS_BYTE;      // RULE1
          next_s.ext_cnt                          = s.ext_cnt + 3'h1;
          if (s.ext_cnt + 3'h1 == s.ext_need) begin
            next_s.st = S_CALC;
          end
        end
      end
      S_CALC: begin
        next_s.st     = S_FIN;
        next_s.wr_num = s.rn;
        case (s.mode)
          `MODE_AUTODEC: begin
            next_s.wr_en   = 1'b1;                                  // RULE14
            next_s.wr_data = base - size_bytes(s.dtype);            // RULE14
            next_s.oa      = base - size_bytes(s.dtype);
          end
          `MODE_AUTOINC: begin
            next_s.oa      = base;                                  // RULE18 RULE17
            next_s.wr_en   = 1'b1;                                  // RULE18
            next_s.wr_data = base + size_bytes(s.dtype);            // RULE18 RULE14
          end
          `MODE_AUTOINC_DEF: begin
            if (s.rn == `REG_PC) begin
              next_s.oa = s.ext;
            end else begin
              next_s.oa      = base;
              next_s.mem_req = 1'b1;
              next_s.st      = S_MEM;
              next_s.wr_en   = 1'b1;
              next_s.wr_data = base + `ADDR_LONG_SIZE;
            end
          end
          `MODE_BDISP_DEF, `MODE_WDISP_DEF, `MODE_LDISP_DEF: begin
            next_s.oa      = base + disp_ext(s.ext, s.ext_need);    // RULE3
            next_s.mem_req = 1'b1;                                  // RULE3
            next_s.st      = S_MEM;
          end
          `MODE_BDISP, `MODE_WDISP, `MODE_LDISP: begin
            next_s.oa = base + disp_ext(s.ext, s.ext_need);         // RULE2
          end
          default: next_s.oa = base;
        endcase
        if (s.indexed && next_s.st == S_FIN) begin
          next_s.oa = next_s.oa + scaled(REG_X_DATA, s.dtype);      // RULE13
        end
      end
      S_MEM: begin
        if (MEM_ACK) begin
          next_s.mem_req = 1'b0;
          next_s.oa      = s.indexed ? MEM_DATA + scaled(REG_X_DATA, s.dtype)
                                     : MEM_DATA;                    // RULE3 RULE13
          next_s.st      = S_FIN;
        end
      end
      S_FIN:   next_s.st = S_IDLE;
      default: next_s.st = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      s          <= '0;
      s.st       <= S_IDLE;
      s.acc      <= ACC_READ;
      s.dtype    <= DT_BYTE;
    end else begin
      s <= next_s;
    end
  end

  assign DONE             = (s.st == S_FIN);
  assign MEM_REQ          = s.mem_req;
  assign MEM_ADDR         = s.oa;
  assign OPERAND_LOCATION = s.oa;
  assign OPND_IS_LITERAL  = s.is_lit;
  assign LITERAL_VALUE    = s.lit;
  assign OPND_IN_REG      = s.in_reg;
  assign UPDATED_PC       = (s.mode == `MODE_AUTOINC && s.rn == `REG_PC && s.wr_en)
                            ? s.wr_data : s.pc;
  assign REG_WR_EN        = DONE && s.wr_en && !s.fault;            // RULE19
  assign REG_WR_NUM       = s.wr_num;
  assign REG_WR_DATA      = s.wr_data;
  assign FAULT            = DONE && s.fault;                        // RULE19
  assign FAULT_TYPE       = s.fault_type;

  sequence q_lit_bad;
    accept && s.st == S_SPEC && IS_BYTE[7:6] == 2'b00 && s.acc != ACC_READ;
  endsequence
  sequence q_fault_end(logic [1:0] ft);
    DONE && FAULT && FAULT_TYPE == ft;
  endsequence

  a_literal_access_fault: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE9
    q_lit_bad |=> q_fault_end(`FAULT_ILLEGAL)) else $error("literal access not faulted");
  a_pc_index_fault: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE15
    accept && s.st == S_SPEC && IS_BYTE == {`MODE_INDEX, `REG_PC}
    |=> q_fault_end(`FAULT_RESERVED)) else $error("PC index not faulted");
  a_index_base_fault: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE11
    accept && s.st == S_BASE && IS_BYTE[7:4] <= `MODE_REG
    |=> q_fault_end(`FAULT_ILLEGAL)) else $error("bad index base not faulted");
  a_fault_no_update: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE19
    s.fault |-> !REG_WR_EN && !MEM_REQ) else $error("update despite fault");
  a_literal_integer: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE5
    accept && s.st == S_SPEC && IS_BYTE[7:6] == 2'b00 && s.acc == ACC_READ
    && s.dtype == DT_LONG |=> DONE && LITERAL_VALUE == {122'h0, $past(IS_BYTE[5:0])})
    else $error("integer literal wrong");
  a_long_disp_wait: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE1
    accept && s.st == S_SPEC && IS_BYTE[7:4] == `MODE_LDISP
    |=> s.st == S_EXT && s.ext_need == 3'h4) else $error("longword extension not awaited");
  a_autoinc_step: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE18
    s.st == S_CALC && s.mode == `MODE_AUTOINC && s.rn != `REG_PC && !s.indexed
    |=> DONE && REG_WR_EN && OPERAND_LOCATION == $past(REG_A_DATA)
    && REG_WR_DATA == $past(REG_A_DATA) + size_bytes($past(s.dtype)))
    else $error("autoincrement order wrong");
  a_deferred_finish: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE3
    MEM_REQ && MEM_ACK && !s.indexed |=> DONE && OPERAND_LOCATION == $past(MEM_DATA))
    else $error("deferred address not taken");
  a_done_single: assert property (@(posedge CLK_SYS) disable iff (RST)
    DONE |=> !DONE) else $error("done longer than one cycle");

endmodule : operand_specifier_address_unit

/* core/opspec_cfg.svh */
// Encodings and constants for the operand specifier address unit
`ifndef OPSPEC_CFG_SVH
`define OPSPEC_CFG_SVH

`define MODE_INDEX        4'h4
`define MODE_REG          4'h5
`define MODE_REG_DEF      4'h6
`define MODE_AUTODEC      4'h7
`define MODE_AUTOINC      4'h8
`define MODE_AUTOINC_DEF  4'h9
`define MODE_BDISP        4'ha
`define MODE_BDISP_DEF    4'hb
`define MODE_WDISP        4'hc
`define MODE_WDISP_DEF    4'hd
`define MODE_LDISP        4'he
`define MODE_LDISP_DEF    4'hf
`define REG_PC            4'hf
`define FAULT_NONE        2'h0
`define FAULT_ILLEGAL     2'h1
`define FAULT_RESERVED    2'h2
`define BIAS_FD           8'h80
`define BIAS_G            11'h400
`define BIAS_H            15'h4000
`define ADDR_LONG_SIZE    32'h4

`endif

/* core/opspec_pkg.sv */
// Types for the operand specifier address unit
package opspec_pkg;

  typedef enum logic [3:0] {
    DT_BYTE = 4'h0,
    DT_WORD = 4'h1,
    DT_LONG = 4'h2,
    DT_QUAD = 4'h3,
    DT_OCTA = 4'h4,
    DT_FFLT = 4'h5,
    DT_DFLT = 4'h6,
    DT_GFLT = 4'h7,
    DT_HFLT = 4'h8
  } dtype_t;

  typedef enum logic [1:0] {
    ACC_READ   = 2'h0,
    ACC_MODIFY = 2'h1,
    ACC_WRITE  = 2'h2,
    ACC_ADDR   = 2'h3
  } access_t;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_SPEC = 7'h02,
    S_BASE = 7'h04,
    S_EXT  = 7'h08,
    S_CALC = 7'h10,
    S_MEM  = 7'h20,
    S_FIN  = 7'h40
  } state_t;

  typedef struct packed {
    state_t       st;
    access_t      acc;
    dtype_t       dtype;
    logic         indexed;
    logic [3:0]   rx;
    logic [3:0]   mode;
    logic [3:0]   rn;
    logic [2:0]   ext_need;
    logic [2:0]   ext_cnt;
    logic [31:0]  ext;
    logic [31:0]  pc;
    logic         fault;
    logic [1:0]   fault_type;
    logic         in_reg;
    logic [31:0]  oa;
    logic [127:0] lit;
    logic         is_lit;
    logic         mem_req;
    logic         wr_en;
    logic [3:0]   wr_num;
    logic [31:0]  wr_data;
  } unit_state_t;

endpackage : opspec_pkg

/* verif/stream_mem_model.sv */
// Instruction stream, deferred longword memory and register file model
`timescale 1ns/1ns

module stream_mem_model (
  input  wire logic        clk,        // Processor clock
  input  wire logic        rst,        // Reset, active high
  input  wire logic        is_ready,   // Unit takes a byte
  output logic             is_valid,   // Byte offered
  output logic [7:0]       is_byte,    // Stream byte
  output logic [31:0]      is_pc,      // Address of the byte
  input  wire logic [3:0]  reg_a_num,  // Base register number
  output logic [31:0]      reg_a_data, // Base register contents
  input  wire logic [3:0]  reg_x_num,  // Index register number
  output logic [31:0]      reg_x_data, // Index register contents
  input  wire logic        mem_req,    // Longword read request
  input  wire logic [31:0] mem_addr,   // Longword address
  output logic             mem_ack,    // Read answered
  output logic [31:0]      mem_data    // Longword read
);
  logic [7:0]  stream [0:7];
  logic [31:0] regs [0:15];
  logic [31:0] base_pc = 32'h0;
  int          n = 0;
  int          p = 0;
  int          wait_cnt = 0;
  int          delay = 0;
  int          acks = 0;

  assign reg_a_data = regs[reg_a_num];
  assign reg_x_data = regs[reg_x_num];

  task automatic load(input logic [63:0] b, input int cnt, input logic [31:0] pc0);
    for (int i = 0; i < 8; i++) begin
      stream[i] = b[8*i +: 8];
    end
    n = cnt;
    p = 0;
    base_pc = pc0;
  endtask : load

  always @(posedge clk) begin
    if (is_valid && is_ready) begin
      p <= p + 1;
    end
  end

  // An empty stream shows changing data, never the last value; memory data inverts once after each answer, then holds
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      is_valid <= 1'b0;
      is_byte  <= 8'h00;
      is_pc    <= 32'h0;
      mem_ack  <= 1'b0;
      mem_data <= 32'h0;
      wait_cnt <= 0;
    end else begin
      is_valid <= (p < n);
      is_byte  <= (p < n) ? stream[p] : ~is_byte;
      is_pc    <= base_pc + 32'(p);
      if (mem_ack) begin
        mem_ack  <= 1'b0;
        mem_data <= ~mem_data;
        wait_cnt <= 0;
      end else if (mem_req && wait_cnt >= delay) begin
        mem_ack  <= 1'b1;
        mem_data <= {mem_addr[15:0], ~mem_addr[15:0]};
        acks     <= acks + 1;
      end else if (mem_req) begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule : stream_mem_model

/* verif/tb_operand_specifier_address_unit.sv */
// Self-checking bench for the operand specifier address unit
`timescale 1ns/1ns
`include "opspec_cfg.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; $display("unexpected %s expected %h seen %h", nm, e, g); end end

module tb_operand_specifier_address_unit import opspec_pkg::*; ;
  logic         CLK_SYS, RST, START, IS_VALID, IS_READY, MEM_REQ, MEM_ACK, DONE;
  logic         OPND_IS_LITERAL, OPND_IN_REG, REG_WR_EN, FAULT;
  logic [1:0]   ACCESS, FAULT_TYPE;
  logic [3:0]   DATA_TYPE, REG_A_NUM, REG_X_NUM, REG_WR_NUM;
  logic [7:0]   IS_BYTE;
  logic [31:0]  IS_PC, REG_A_DATA, REG_X_DATA, MEM_ADDR, MEM_DATA;
  logic [31:0]  OPERAND_LOCATION, UPDATED_PC, REG_WR_DATA;
  logic [127:0] LITERAL_VALUE;
  int           num_errors, compares, a0;

  operand_specifier_address_unit operand_specifier_address_unit_inst (
    .CLK_SYS(CLK_SYS), .RST(RST), .START(START), .ACCESS(ACCESS), .DATA_TYPE(DATA_TYPE),
    .IS_VALID(IS_VALID), .IS_BYTE(IS_BYTE), .IS_PC(IS_PC), .IS_READY(IS_READY),
    .REG_A_NUM(REG_A_NUM), .REG_A_DATA(REG_A_DATA), .REG_X_NUM(REG_X_NUM),
    .REG_X_DATA(REG_X_DATA), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK),
    .MEM_DATA(MEM_DATA), .DONE(DONE), .OPERAND_LOCATION(OPERAND_LOCATION),
    .OPND_IS_LITERAL(OPND_IS_LITERAL), .LITERAL_VALUE(LITERAL_VALUE),
    .OPND_IN_REG(OPND_IN_REG), .UPDATED_PC(UPDATED_PC), .REG_WR_EN(REG_WR_EN),
    .REG_WR_NUM(REG_WR_NUM), .REG_WR_DATA(REG_WR_DATA), .FAULT(FAULT), .FAULT_TYPE(FAULT_TYPE));

  stream_mem_model stream_mem_model_inst (
    .clk(CLK_SYS), .rst(RST), .is_ready(IS_READY), .is_valid(IS_VALID), .is_byte(IS_BYTE),
    .is_pc(IS_PC), .reg_a_num(REG_A_NUM), .reg_a_data(REG_A_DATA), .reg_x_num(REG_X_NUM),
    .reg_x_data(REG_X_DATA), .mem_req(MEM_REQ), .mem_addr(MEM_ADDR), .mem_ack(MEM_ACK),
    .mem_data(MEM_DATA));

  initial CLK_SYS = 1'b0;
  always #2 CLK_SYS = ~CLK_SYS;

  function automatic logic [31:0] rv(input int i);
    return (i == 2) ? 32'h5 : 32'h1000 * i;
  endfunction : rv

  task automatic close_out();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  // Runs one specifier and returns in the cycle that DONE is high
  task automatic issue(input access_t a, input dtype_t d, input logic [63:0] b, input int cnt,
                       input logic [31:0] pc0);
    @(posedge CLK_SYS);
    #1;
    stream_mem_model_inst.load(b, cnt, pc0);
    a0 = stream_mem_model_inst.acks;
    @(negedge CLK_SYS);
    START = 1'b1;
    ACCESS = a;
    DATA_TYPE = d;
    @(negedge CLK_SYS);
    START = 1'b0;
    for (int k = 0; k < 40 && DONE !== 1'b1; k++) begin
      @(posedge CLK_SYS);
      #1;
    end
    if (DONE !== 1'b1) begin
      num_errors++;
      close_out();
    end
  endtask : issue

  task automatic disp_modes();
    logic [31:0] d, mid, oa;
    logic [31:0] pc0;
    int          len;
    for (int m = 0; m < 6; m++) for (int r = 0; r < 2; r++) begin
      len = 1 << (m / 2);
      d = (m < 2) ? 32'hffffff80 : (m < 4) ? 32'hffff8001 : 32'h12345678;
      pc0 = 32'h4000 + 32'(m * 16);
      mid = (r ? pc0 + 32'(1 + len) : rv(3)) + d;
      oa = m[0] ? {mid[15:0], ~mid[15:0]} : mid;
      stream_mem_model_inst.delay = m;
      issue(ACC_READ, DT_LONG, {24'h0, d, 4'(10 + m), (r ? 4'hf : 4'h3)}, 1 + len, pc0);
      `CHK("operand location", oa, OPERAND_LOCATION)
      `CHK("updated pc", pc0 + 32'(1 + len), UPDATED_PC)
      `CHK("memory reads", m % 2, stream_mem_model_inst.acks - a0)
      `CHK("register write", 1'b0, REG_WR_EN)
      `CHK("register operand", 1'b0, OPND_IN_REG)
      `CHK("literal operand", 1'b0, OPND_IS_LITERAL)
    end
  endtask : disp_modes

  task automatic literal_ops();
    logic [127:0] f;
    for (int t = 0; t < 9; t++) begin
      f = (t < 5) ? 128'h3f : (t < 7) ? {112'h0, 1'b0, 8'h85, 3'h3, 4'h0}
        : (t == 7) ? {112'h0, 1'b0, 11'h405, 3'h3, 1'b0} : {96'h0, 3'h3, 29'h4005};
      issue(ACC_READ, dtype_t'(t), (t < 5) ? 64'h3f : 64'h2b, 1, 32'h4800);
      `CHK("literal flag", 1'b1, OPND_IS_LITERAL)
      `CHK("literal value", f, LITERAL_VALUE)
      `CHK("literal fault", 1'b0, FAULT)
      `CHK("literal in register", 1'b0, OPND_IN_REG)
    end
  endtask : literal_ops

  task automatic lit_faults();
    for (int a = 1; a < 4; a++) begin
      issue(access_t'(a), DT_LONG, 64'h07, 1, 32'h4900);
      `CHK("fault", 1'b1, FAULT)
      `CHK("fault type", `FAULT_ILLEGAL, FAULT_TYPE)
      `CHK("register write", 1'b0, REG_WR_EN)
    end
  endtask : lit_faults

  task automatic index_disp();
    for (int t = 0; t < 5; t++) begin
      issue(ACC_ADDR, dtype_t'(t), 64'h10a342, 3, 32'h5000);
      `CHK("indexed location", rv(3) + 32'h10 + (rv(2) << t), OPERAND_LOCATION)
      `CHK("updated pc", 32'h5003, UPDATED_PC)
    end
  endtask : index_disp

  task automatic index_faults();
    logic [23:0] sp [4] = '{24'h000542, 24'h005342, 24'h004142, 24'h04b34f};
    for (int i = 0; i < 4; i++) begin
      issue(ACC_READ, DT_LONG, {40'h0, sp[i]}, 3, 32'h6000);
      `CHK("fault", 1'b1, FAULT)
      `CHK("fault type", (i == 3) ? `FAULT_RESERVED : `FAULT_ILLEGAL, FAULT_TYPE)
      `CHK("register write", 1'b0, REG_WR_EN)
      `CHK("memory reads", 0, stream_mem_model_inst.acks - a0)
    end
  endtask : index_faults

  // Index register 2 never equals the stepped base register 6
  task automatic autoinc_ops();
    issue(ACC_READ, DT_WORD, 64'h86, 1, 32'h7000);
    `CHK("autoinc location", rv(6), OPERAND_LOCATION)
    `CHK("autoinc write", 1'b1, REG_WR_EN)
    `CHK("autoinc number", 4'h6, REG_WR_NUM)
    `CHK("autoinc data", rv(6) + 32'h2, REG_WR_DATA)
    issue(ACC_READ, DT_QUAD, 64'h8642, 2, 32'h7010);
    `CHK("autoinc indexed", rv(6) + rv(2) * 8, OPERAND_LOCATION)
    `CHK("autoinc step", rv(6) + 32'h8, REG_WR_DATA)
    issue(ACC_READ, DT_OCTA, 64'h7642, 2, 32'h7020);
    `CHK("autodec indexed", rv(6) - 32'h10 + rv(2) * 16, OPERAND_LOCATION)
    `CHK("autodec step", rv(6) - 32'h10, REG_WR_DATA)
    // Deferred base R6 reads a longword, then the index is added
    issue(ACC_READ, DT_LONG, 64'h9642, 2, 32'h7030);
    `CHK("deferred indexed", 32'h60009fff + rv(2) * 4, OPERAND_LOCATION)
    `CHK("deferred reads", 1, stream_mem_model_inst.acks - a0)
  endtask : autoinc_ops

  task automatic immediate_index();
    for (int k = 0; k < 2; k++) begin
      issue(ACC_READ, DT_LONG, k ? 64'hffffffff8f42 : 64'h000000008f42, 6, 32'h8000);
      `CHK("immediate indexed", 32'h8002 + rv(2) * 4, OPERAND_LOCATION)
    end
  endtask : immediate_index

  initial begin
    RST = 1'b1;
    START = 1'b0;
    ACCESS = 2'h0;
    DATA_TYPE = 4'h0;
    num_errors = 0;
    compares = 0;
    for (int i = 0; i < 16; i++) stream_mem_model_inst.regs[i] = rv(i);
    repeat (2) @(negedge CLK_SYS);
    RST = 1'b0;
    disp_modes();
    literal_ops();
    lit_faults();
    index_disp();
    index_faults();
    autoinc_ops();
    immediate_index();
    close_out();
  end
endmodule : tb_operand_specifier_address_unit
